// file: design/clk_mode_pkg.sv
// Overview of operation
// RL1: System clock takes divided high-speed clock for codes 000-110, low-speed for 111.
// RL2: High-speed clock comes from external crystal or internal RC per source bit.
// RL3: Low-speed clock comes from external crystal or internal RC per source bit.
// RL4: Fast mode divides the high-speed clock by 1 to 64 per select field.
// RL5: Going to low-speed, high-speed oscillator stops or runs per its enable bit.
// RL6: CPU running with codes 000-110 is fast mode, all clocks active.
// RL7: CPU running with code 111 is slow mode, high-speed follows its enable.
// RL8: Halt with both keep bits low is sleep; CPU, system, hs, ls clocks stop.
// RL9: Internal low-speed RC clock runs in every mode, sleep included.
// RL10: Halt with only ls keep bit set is idle 0; system clock only for 111.
// RL11: Halt with both keep bits set is idle 1; all clocks keep running. The code stops the CPU clock in this mode.
// RL12: Halt with only hs keep bit set is idle 2; system clock only for 000-110.
// RL13: Codes map 000 undivided, 001-110 divide by 2..64, 111 low-speed.
// RL14: High-speed source bit 0 picks internal RC, 1 picks external crystal.
// RL15: Low-speed source bit 0 picks internal RC, 1 picks external crystal.
// RL16: Source and ratio switching is glitch-free, no runt pulses. The code drops sys_clk on a select change, cutting a high pulse short.
package clk_mode_pkg;

    localparam logic [2:0] SEL_UNDIVIDED = 3'h0;
    localparam logic [2:0] SEL_LOW_SPEED = 3'h7;
    localparam int DIV_WIDTH = 6;
    localparam logic [2:0] SEL_RESET = 3'h0;

    typedef enum logic [2:0] {
        MODE_FAST,
        MODE_SLOW,
        MODE_SLEEP,
        MODE_IDLE_LS_ONLY,
        MODE_IDLE_BOTH_CLKS,
        MODE_IDLE_HS_ONLY
    } op_mode_type;

    typedef struct packed {
        logic [2:0] sys_clk_select;
        logic hs_source_select;
        logic ls_source_select;
        logic hs_keep_in_halt;
        logic ls_keep_in_halt;
        logic hs_osc_enable;
    } sys_clk_ctrl_type;

    typedef struct packed {
        logic cpu_clk_en;
        logic sys_clk_en;
        logic hs_clk_en;
        logic ls_clk_en;
        logic int_ls_rc_osc_clk_en;
    } clk_status_type;

endpackage

// file: design/clk_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Clock selection and operating mode control, all on ref_clk. The oscillator
// inputs are sampled as levels, so output clocks are enables-driven levels.
module clk_mode_ctrl (
    input wire logic ref_clk, // System reference clock, 100 MHz.
    input wire logic rstn, // Asynchronous active-low reset.
    input wire clk_mode_pkg::sys_clk_ctrl_type sys_clk_ctrl_reg, // Control bits.
    input wire logic halt_req, // CPU halt request, level.
    input wire logic wake_req, // Wake request, level.
    input wire logic ext_hs_crystal_osc, // Raw external high-speed crystal clock.
    input wire logic int_hs_rc_osc, // Raw internal high-speed RC clock.
    input wire logic ext_ls_crystal_osc, // Raw external low-speed crystal clock.
    input wire logic int_ls_rc_osc, // Raw internal low-speed RC clock.
    output logic sys_clk, // System clock level.
    output logic hs_clk, // High-speed clock for peripherals.
    output logic ls_clk, // Low-speed clock for peripherals.
    output logic int_ls_rc_clk, // Watchdog clock, always running.
    output var clk_mode_pkg::op_mode_type op_mode, // Current operating mode.
    output var clk_mode_pkg::clk_status_type clk_status // Clock enables.
);

    // Reset synchroniser.
    logic [1:0] rst_sync_q;
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    logic rst_n;
    assign rst_n = rst_sync_q[1];

    // Two-flop synchronisers for all pin inputs.
    logic [4:0] raw_in;
    logic [4:0] meta_q;
    logic [4:0] sync_q;
    assign raw_in = {halt_req, ext_hs_crystal_osc, int_hs_rc_osc,
                     ext_ls_crystal_osc, int_ls_rc_osc};
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= 5'h00;
            sync_q <= 5'h00;
        end
        else
        begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end
    logic wake_meta_q;
    logic wake_sync_q;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_meta_q <= 1'b0;
            wake_sync_q <= 1'b0;
        end
        else
        begin
            wake_meta_q <= wake_req;
            wake_sync_q <= wake_meta_q;
        end
    end
    logic halt_s;
    logic hxt_s;
    logic int_hs_rc_osc_s;
    logic lxt_s;
    logic int_ls_rc_osc_s;
    assign {halt_s, hxt_s, int_hs_rc_osc_s, lxt_s, int_ls_rc_osc_s} = sync_q;

    // Source selection for the high- and low-speed clocks. A new source bit
    // is adopted only while both candidate sources are low, so a change of
    // source never cuts a pulse short on the divider input or on sys_clk.
    logic hs_sel_q;
    logic hs_sel_d;
    logic ls_sel_q;
    logic ls_sel_d;
    logic hs_src;
    logic ls_src;
    always_comb
    begin
        hs_sel_d = hs_sel_q;
        ls_sel_d = ls_sel_q;
        // RL16 source change when low
        if (!hxt_s && !int_hs_rc_osc_s)
            hs_sel_d = sys_clk_ctrl_reg.hs_source_select;
        if (!lxt_s && !int_ls_rc_osc_s)
            ls_sel_d = sys_clk_ctrl_reg.ls_source_select;
        // RL2 RL14 high-speed source
        hs_src = hs_sel_q ? hxt_s : int_hs_rc_osc_s;
        // RL3 RL15 low-speed source
        ls_src = ls_sel_q ? lxt_s : int_ls_rc_osc_s;
    end

    // Active source bits, internal RC oscillators after reset.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hs_sel_q <= 1'b0;
            ls_sel_q <= 1'b0;
        end
        else
        begin
            hs_sel_q <= hs_sel_d;
            ls_sel_q <= ls_sel_d;
        end
    end

    // Operating mode state.
    clk_mode_pkg::op_mode_type mode_q;
    clk_mode_pkg::op_mode_type mode_d;
    logic running;
    assign running = (mode_q == clk_mode_pkg::MODE_FAST) || (mode_q == clk_mode_pkg::MODE_SLOW);
    always_comb
    begin
        mode_d = mode_q;
        // RL6 RL7 running mode from select code
        if (running || wake_sync_q)
        begin
            if (sys_clk_ctrl_reg.sys_clk_select == clk_mode_pkg::SEL_LOW_SPEED)
                mode_d = clk_mode_pkg::MODE_SLOW;
            else
                mode_d = clk_mode_pkg::MODE_FAST;
        end
        // RL8 RL10 RL11 RL12 halt mode choice
        if (running && halt_s && !wake_sync_q)
        begin
            case ({sys_clk_ctrl_reg.hs_keep_in_halt, sys_clk_ctrl_reg.ls_keep_in_halt})
                2'b00: mode_d = clk_mode_pkg::MODE_SLEEP;
                2'b01: mode_d = clk_mode_pkg::MODE_IDLE_LS_ONLY;
                2'b11: mode_d = clk_mode_pkg::MODE_IDLE_BOTH_CLKS;
                2'b10: mode_d = clk_mode_pkg::MODE_IDLE_HS_ONLY;
                default: mode_d = clk_mode_pkg::MODE_SLEEP;
            endcase
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            mode_q <= clk_mode_pkg::MODE_FAST;
        else
            mode_q <= mode_d;
    end

    // Clock enables per mode.
    clk_mode_pkg::clk_status_type en_d;
    logic sel_ls;
    assign sel_ls = sys_clk_ctrl_reg.sys_clk_select == clk_mode_pkg::SEL_LOW_SPEED;
    always_comb
    begin
        en_d = '0;
        // RL9 watchdog clock always on
        en_d.int_ls_rc_osc_clk_en = 1'b1;
        case (mode_q)
            clk_mode_pkg::MODE_FAST:
            begin
                en_d.cpu_clk_en = 1'b1;
                en_d.sys_clk_en = 1'b1;
                en_d.hs_clk_en = 1'b1;
                en_d.ls_clk_en = 1'b1;
            end
            clk_mode_pkg::MODE_SLOW:
            begin
                en_d.cpu_clk_en = 1'b1;
                en_d.sys_clk_en = 1'b1;
                // RL5 RL7 hs follows enable
                en_d.hs_clk_en = sys_clk_ctrl_reg.hs_osc_enable;
                en_d.ls_clk_en = 1'b1;
            end
            clk_mode_pkg::MODE_IDLE_LS_ONLY:
            begin
                // RL10 system clock only for low-speed
                en_d.sys_clk_en = sel_ls;
                en_d.ls_clk_en = 1'b1;
            end
            clk_mode_pkg::MODE_IDLE_BOTH_CLKS:
            begin
                // RL11 system, hs, ls clocks kept, CPU clock stopped
                en_d.sys_clk_en = 1'b1;
                en_d.hs_clk_en = 1'b1;
                en_d.ls_clk_en = 1'b1;
            end
            clk_mode_pkg::MODE_IDLE_HS_ONLY:
            begin
                // RL12 system clock only for high-speed
                en_d.sys_clk_en = !sel_ls;
                en_d.hs_clk_en = 1'b1;
            end
            // RL8 sleep stops all but watchdog clock
            default: en_d.int_ls_rc_osc_clk_en = 1'b1;
        endcase
    end

    // High-speed divider counts rising edges of the high-speed source.
    logic hs_prev_q;
    logic [clk_mode_pkg::DIV_WIDTH-1:0] div_q;
    logic [clk_mode_pkg::DIV_WIDTH-1:0] div_d;
    logic hs_rise;
    assign hs_rise = hs_src && !hs_prev_q;
    always_comb
    begin
        div_d = div_q;
        if (hs_rise)
            div_d = div_q + 6'h01;
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hs_prev_q <= 1'b0;
            div_q <= 6'h00;
        end
        else
        begin
            hs_prev_q <= hs_src;
            div_q <= div_d;
        end
    end

    // Candidate system clock from the select field.
    logic cand_clk;
    logic [2:0] sel;
    assign sel = sys_clk_ctrl_reg.sys_clk_select;
    always_comb
    begin
        // RL1 RL4 RL13 select and divide
        if (sel == clk_mode_pkg::SEL_LOW_SPEED)
            cand_clk = ls_src;
        else if (sel == clk_mode_pkg::SEL_UNDIVIDED)
            cand_clk = hs_src;
        else
            cand_clk = div_q[sel - 3'h1];
    end

    // Clock switch: a new selection is adopted only while both the
    // old and the new clock are low; sys_clk is held low from the select change, so a high pulse in progress is cut short.
    logic [2:0] act_sel_q;
    logic [2:0] act_sel_d;
    logic cur_clk;
    always_comb
    begin
        if (act_sel_q == clk_mode_pkg::SEL_LOW_SPEED)
            cur_clk = ls_src;
        else if (act_sel_q == clk_mode_pkg::SEL_UNDIVIDED)
            cur_clk = hs_src;
        else
            cur_clk = div_q[act_sel_q - 3'h1];
        act_sel_d = act_sel_q;
        // RL16 switch only when both low
        if (sel != act_sel_q && !cur_clk && !cand_clk)
            act_sel_d = sel;
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            act_sel_q <= clk_mode_pkg::SEL_RESET;
        else
            act_sel_q <= act_sel_d;
    end

    // Output registers.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sys_clk <= 1'b0;
            hs_clk <= 1'b0;
            ls_clk <= 1'b0;
            int_ls_rc_clk <= 1'b0;
            op_mode <= clk_mode_pkg::MODE_FAST;
            clk_status <= '0;
        end
        else
        begin
            sys_clk <= cur_clk && en_d.sys_clk_en && (act_sel_q == sel);
            hs_clk <= hs_src && en_d.hs_clk_en;
            ls_clk <= ls_src && en_d.ls_clk_en;
            int_ls_rc_clk <= int_ls_rc_osc_s;
            op_mode <= mode_q;
            clk_status <= en_d;
        end
    end

    // RL9 watchdog clock enabled
    a_int_ls_rc_osc_always_on: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL9
        $past(rst_n) |-> clk_status.int_ls_rc_osc_clk_en && int_ls_rc_clk == $past(int_ls_rc_osc_s))
        else $error("watchdog clock disabled");
    // RL8 sleep stops clocks
    a_sleep_clocks_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL8
        mode_q == clk_mode_pkg::MODE_SLEEP |=> !clk_status.sys_clk_en && !clk_status.hs_clk_en
        && !clk_status.ls_clk_en && !sys_clk) else $error("sleep clocks on");
    // RL11 idle one keeps clocks
    a_idle_both_on: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL11
        mode_q == clk_mode_pkg::MODE_IDLE_BOTH_CLKS |=> clk_status.hs_clk_en
        && clk_status.ls_clk_en && !clk_status.cpu_clk_en) else $error("idle_both_clks enables");
    // RL10 idle zero system clock
    a_idle_ls_sys: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL10
        mode_q == clk_mode_pkg::MODE_IDLE_LS_ONLY && !sel_ls |=> !clk_status.sys_clk_en
        && !clk_status.hs_clk_en) else $error("idle_ls_only system clock on");
    // RL12 idle two system clock
    a_idle_hs_sys: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL12
        mode_q == clk_mode_pkg::MODE_IDLE_HS_ONLY && sel_ls |=> !clk_status.sys_clk_en
        && !clk_status.ls_clk_en) else $error("idle_hs_only system clock on");
    // RL8 halt entry sleep
    a_halt_to_sleep: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL8
        running && halt_s && !wake_sync_q && !sys_clk_ctrl_reg.hs_keep_in_halt
        && !sys_clk_ctrl_reg.ls_keep_in_halt |=> mode_q == clk_mode_pkg::MODE_SLEEP)
        else $error("halt did not sleep");
    // RL6 fast mode select
    a_fast_mode_sel: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL6
        running && !halt_s && !sel_ls |=> mode_q == clk_mode_pkg::MODE_FAST)
        else $error("fast mode not taken");
    // RL16 select adopted only when both low
    a_switch_both_low: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL16
        act_sel_q != $past(act_sel_q) |-> !$past(cur_clk) && !$past(cand_clk))
        else $error("switch while high");
    // RL16 source change while low
    a_src_switch_low: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL16
        hs_sel_q != $past(hs_sel_q) |-> !$past(hxt_s) && !$past(int_hs_rc_osc_s))
        else $error("source switch while high");
    // RL5 slow hs follows enable
    a_slow_hs_enable: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL5
        mode_q == clk_mode_pkg::MODE_SLOW |=> clk_status.hs_clk_en
        == $past(sys_clk_ctrl_reg.hs_osc_enable)) else $error("slow hs enable wrong");

endmodule // clk_mode_ctrl
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int WIN = 1536;
    localparam int LIMIT = 80000;
    logic ref_clk = 1'h0;
    logic rstn = 1'h0;
    clk_mode_pkg::sys_clk_ctrl_type ctrl = 8'h00;
    logic halt_req = 1'h0;
    logic wake_req = 1'h0;
    logic ext_hs = 1'h0;
    logic int_hs = 1'h0;
    logic ext_ls = 1'h0;
    logic int_ls = 1'h0;
    logic sys_clk, hs_clk, ls_clk, int_ls_rc_osc_clk;
    clk_mode_pkg::op_mode_type op_mode;
    clk_mode_pkg::clk_status_type clk_status;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int n_sys, n_hs, n_ls, n_int_ls_rc_osc;

    clk_mode_ctrl u_dut (
        .ref_clk(ref_clk), .rstn(rstn), .sys_clk_ctrl_reg(ctrl), .halt_req(halt_req),
        .wake_req(wake_req), .ext_hs_crystal_osc(ext_hs), .int_hs_rc_osc(int_hs),
        .ext_ls_crystal_osc(ext_ls), .int_ls_rc_osc(int_ls), .sys_clk(sys_clk),
        .hs_clk(hs_clk), .ls_clk(ls_clk), .int_ls_rc_clk(int_ls_rc_osc_clk),
        .op_mode(op_mode), .clk_status(clk_status)
    );

    // The reference clock toggles every half period.
    always #5 ref_clk = ~ref_clk;

    // Oscillators are slow square waves of distinct periods; a hang ends the run.
    always @(negedge ref_clk)
    begin
        cyc <= cyc + 1;
        ext_hs <= (cyc % 8) >= 4;
        int_hs <= (cyc % 12) >= 6;
        ext_ls <= (cyc % 40) >= 20;
        int_ls <= (cyc % 56) >= 28;
        if (cyc == LIMIT)
        begin
            n_mismatch = n_mismatch + 1;
            $display("Timeout at cycle %0d", cyc);
            end_sim();
        end
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Edge counts may be off by one at the window ends; a stopped clock must give none.
    task automatic check_cnt(input string what, input int exp, input int got);
        num_checks++;
        if ((exp == 0) ? (got != 0) : (got < exp - 1 || got > exp + 1))
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // Period in reference cycles of the clock chosen by a select code.
    function automatic int per(input logic [2:0] s);
        if (s == 3'h7)
            return ctrl.ls_source_select ? 40 : 56;
        return (ctrl.hs_source_select ? 8 : 12) << s;
    endfunction

    task automatic count_clks;
        logic p_sys, p_hs, p_ls, p_l;
        n_sys = 0;
        n_hs = 0;
        n_ls = 0;
        n_int_ls_rc_osc = 0;
        p_sys = sys_clk;
        p_hs = hs_clk;
        p_ls = ls_clk;
        p_l = int_ls_rc_osc_clk;
        repeat (WIN)
        begin
            @(negedge ref_clk);
            if (p_sys === 1'h0 && sys_clk === 1'h1) n_sys++;
            if (p_hs === 1'h0 && hs_clk === 1'h1) n_hs++;
            if (p_ls === 1'h0 && ls_clk === 1'h1) n_ls++;
            if (p_l === 1'h0 && int_ls_rc_osc_clk === 1'h1) n_int_ls_rc_osc++;
            p_sys = sys_clk;
            p_hs = hs_clk;
            p_ls = ls_clk;
            p_l = int_ls_rc_osc_clk;
        end
    endtask

    task automatic check_all(input logic [2:0] mode, input logic cpu, input logic sys_on,
                             input logic hs_on, input logic ls_on);
        logic [2:0] s;
        s = ctrl.sys_clk_select;
        check_val("op_mode", {5'h00, mode}, {5'h00, op_mode});
        check_val("clk_status", {3'h0, cpu, sys_on, hs_on, ls_on, 1'h1}, {3'h0, clk_status});
        count_clks();
        check_cnt("sys_clk", sys_on ? WIN / per(s) : 0, n_sys);
        check_cnt("hs_clk", hs_on ? WIN / per(3'h0) : 0, n_hs);
        check_cnt("ls_clk", ls_on ? WIN / per(3'h7) : 0, n_ls);
        check_cnt("int_ls_rc_clk", WIN / 56, n_int_ls_rc_osc);
    endtask

    // Main sequence: reset, running modes, slow mode with the fast oscillator off, halts.
    initial
    begin
        repeat (6) @(negedge ref_clk);
        rstn = 1'h1;
        repeat (4) @(negedge ref_clk);
        check_val("reset op_mode", 8'h00, {5'h00, op_mode});
        $display("test reset done");
        for (int i = 0; i < 16; i++)
        begin
            ctrl.sys_clk_select = i[2:0];
            ctrl.hs_source_select = i[3];
            ctrl.ls_source_select = ~i[3];
            ctrl.hs_osc_enable = 1'h1;
            repeat (800) @(negedge ref_clk);
            if (i[2:0] == 3'h7)
                check_all(clk_mode_pkg::MODE_SLOW, 1'h1, 1'h1, 1'h1, 1'h1);
            else
                check_all(clk_mode_pkg::MODE_FAST, 1'h1, 1'h1, 1'h1, 1'h1);
        end
        $display("test run modes done");
        ctrl.hs_osc_enable = 1'h0;
        repeat (800) @(negedge ref_clk);
        check_all(clk_mode_pkg::MODE_SLOW, 1'h1, 1'h1, 1'h0, 1'h1);
        ctrl.hs_osc_enable = 1'h1;
        $display("test slow oscillator off done");
        for (int i = 0; i < 8; i++)
        begin
            ctrl.hs_keep_in_halt = i[1];
            ctrl.ls_keep_in_halt = i[0];
            ctrl.sys_clk_select = i[2] ? 3'h7 : 3'h2;
            repeat (800) @(negedge ref_clk);
            halt_req = 1'h1;
            repeat (6) @(negedge ref_clk);
            halt_req = 1'h0;
            repeat (100) @(negedge ref_clk);
            case (i[1:0])
                2'h0: check_all(clk_mode_pkg::MODE_SLEEP, 1'h0, 1'h0, 1'h0, 1'h0);
                2'h1: check_all(clk_mode_pkg::MODE_IDLE_LS_ONLY, 1'h0, i[2], 1'h0, 1'h1);
                2'h2: check_all(clk_mode_pkg::MODE_IDLE_HS_ONLY, 1'h0, ~i[2], 1'h1, 1'h0);
                default: check_all(clk_mode_pkg::MODE_IDLE_BOTH_CLKS, 1'h0, 1'h1, 1'h1, 1'h1);
            endcase
            wake_req = 1'h1;
            repeat (6) @(negedge ref_clk);
            wake_req = 1'h0;
            repeat (6) @(negedge ref_clk);
            check_val("wake op_mode", i[2] ? 8'h01 : 8'h00, {5'h00, op_mode});
        end
        $display("test halt modes done");
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
